// ---- logic/dmr_map.svh ----
/*
  Offsets, field positions, codes and timing counts for the mode register block.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef DMR_MAP_SVH
`define DMR_MAP_SVH
// ------------------------------------------------------------
// Mode word fields
// ------------------------------------------------------------
`define DMR_BL_LSB        0
`define DMR_BL_MSB        2
`define DMR_BT_BIT        3
`define DMR_RL_LSB        4
`define DMR_RL_MSB        6
`define DMR_OP_LSB        7
`define DMR_OP_MSB        12
`define DMR_DLL_RST_BIT   8
// ------------------------------------------------------------
// Codes
// ------------------------------------------------------------
`define DMR_BL_2          3'h1
`define DMR_BL_4          3'h2
`define DMR_BL_8          3'h3
`define DMR_RL_2          3'h2
`define DMR_RL_3          3'h3
`define DMR_RL_25         3'h6
`define DMR_OP_NORMAL     6'h00
`define DMR_OP_DLL_RESET  6'h02
`define DMR_BANK_BASE     2'h0
`define DMR_BANK_EXT      2'h1
// Extended word fields are chosen positions
`define DMR_EXT_DLL_DIS   0
`define DMR_EXT_DRV_RED   1
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define DMR_DLL_LOCK_CYC  200
`define DMR_RESET_WORD    13'h0000
`endif

// ---- logic/dmr_pkg.sv ----
/*
  Types for the mode register block.
  Assumes the map header is on the include path.
*/
package dmr_pkg;
  `include "dmr_map.svh"
  typedef struct packed {
    logic        valid;
    logic        is_read;
    logic        is_write;
    logic        is_lmr;
    logic        self_refresh_exit;
    logic [1:0]  bank;
    logic [12:0] addr;
  } dmr_cmd_t;
  typedef struct packed {
    logic       valid;
    logic       is_read;
    logic [9:0] column;
  } dmr_beat_t;
  typedef enum logic [1:0] {DMR_IDLE, DMR_BURST} dmr_state_t;
endpackage

// ---- logic/dmr_core.sv ----
/*
  Mode and extended mode registers, burst column sequencing and read latency
  timing for one DDR device. Assumes a decoded command stream on sys_clk,
  one command per cycle, issued only while banks are idle for register loads.
*/
`timescale 1ns/1ps
`include "dmr_map.svh"
// Function
// - Address bits 4..6 give read latency, bits 7..12 give operating mode.
// - Bits 0..2 give burst length, bit 3 gives burst type.
// - Burst lengths 2, 4, 8 for both types, reads and writes alike.
// - Burst wraps in aligned block; low column bits pick the start.
// - Top column bit is 8 for small density, 9 for large.
// - One mode bit picks sequential or interleaved order.
// - Sequential is start plus k modulo length; interleaved is start xor k.
// - First read data appears at edge n plus programmed latency.
// - Latency 2, 2.5, 3; half cycle puts data on falling edge.
// - Zero mode bits 7..12 select normal operation.
// - Bit 8 alone set in mode bits starts a DLL reset.
// - DLL reset bit clears itself; other bits persist until rewritten.
// - Load with bank bits 00 writes the base mode register.
// - Load with bank bits 01 writes the extended register, retained.
// - Extended register sets DLL enable and reduced drive strength.
// - DLL re-enables automatically on self refresh exit.
module dmr_core
  import dmr_pkg::*;
#(
  parameter bit LARGE_DENSITY = 1'b0,
  parameter int LOCK_CYCLES   = `DMR_DLL_LOCK_CYC
)(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire dmr_cmd_t    cmd,
  output dmr_beat_t        beat,
  output logic [2:0]       read_latency_setting,
  output logic             burst_order_bit,
  output logic             dll_enabled,
  output logic             dll_locked,
  output logic             drive_reduced,
  output logic             data_valid,
  output logic             data_on_neg_edge,
  output logic             mode_reserved
);
  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [12:0] mode_reg, mode_next;
  logic [12:0] ext_reg, ext_next;
  logic        dll_rst_reg, dll_rst_next;
  logic        dll_dis_reg, dll_dis_next;
  logic [7:0]  lock_cnt_reg, lock_cnt_next;
  dmr_state_t  state_reg, state_next;
  logic [9:0]  start_reg, start_next;
  logic [2:0]  k_reg, k_next;
  logic [2:0]  len_m1_reg, len_m1_next;
  logic        rd_reg, rd_next;
  logic [3:0]  pipe_reg, pipe_next;
  dmr_beat_t   beat_reg, beat_next;
  logic [2:0]  len_m1;
  logic [2:0]  offs;
  logic [9:0]  col;
  logic [9:0]  col_mask;
  logic        lmr_base, lmr_ext;
  localparam logic [7:0] LOCK_MAX = 8'(LOCK_CYCLES);

  assign lmr_base = cmd.valid && cmd.is_lmr && cmd.bank == `DMR_BANK_BASE;
  assign lmr_ext  = cmd.valid && cmd.is_lmr && cmd.bank == `DMR_BANK_EXT;
  // Top column bit beyond the device width is forced to zero
  assign col_mask = LARGE_DENSITY ? 10'h3ff : 10'h1ff;

  always_comb begin
    unique case (mode_reg[`DMR_BL_MSB:`DMR_BL_LSB])
      `DMR_BL_2: len_m1 = 3'h1;
      `DMR_BL_4: len_m1 = 3'h3;
      `DMR_BL_8: len_m1 = 3'h7;
      default:   len_m1 = 3'h0;
    endcase
  end

  // ------------------------------------------------------------
  // Mode and extended registers, DLL
  // ------------------------------------------------------------
  always_comb begin
    mode_next     = mode_reg;
    ext_next      = ext_reg;
    dll_rst_next  = 1'b0;
    dll_dis_next  = dll_dis_reg;
    lock_cnt_next = lock_cnt_reg;
    if (lmr_base) begin
      mode_next = cmd.addr;
      // Reset bit not kept in the stored word
      mode_next[`DMR_DLL_RST_BIT] = 1'b0;
      dll_rst_next = cmd.addr[`DMR_OP_MSB:`DMR_OP_LSB] == `DMR_OP_DLL_RESET;
    end
    if (lmr_ext) begin
      ext_next     = cmd.addr;
      dll_dis_next = cmd.addr[`DMR_EXT_DLL_DIS];
    end
    if (cmd.valid && cmd.self_refresh_exit)
      dll_dis_next = 1'b0;
    if (dll_dis_next || dll_rst_reg)
      lock_cnt_next = 8'h00;
    else if (lock_cnt_reg != LOCK_MAX)
      lock_cnt_next = lock_cnt_reg + 8'h01;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg     <= `DMR_RESET_WORD;
      ext_reg      <= `DMR_RESET_WORD;
      dll_rst_reg  <= 1'b0;
      dll_dis_reg  <= 1'b0;
      lock_cnt_reg <= 8'h00;
    end else begin
      mode_reg     <= mode_next;
      ext_reg      <= ext_next;
      dll_rst_reg  <= dll_rst_next;
      dll_dis_reg  <= dll_dis_next;
      lock_cnt_reg <= lock_cnt_next;
    end
  end

  assign read_latency_setting = mode_reg[`DMR_RL_MSB:`DMR_RL_LSB];
  assign burst_order_bit      = mode_reg[`DMR_BT_BIT];
  assign dll_enabled          = !dll_dis_reg;
  assign dll_locked           = lock_cnt_reg == LOCK_MAX;
  assign drive_reduced        = ext_reg[`DMR_EXT_DRV_RED];
  assign mode_reserved        = mode_reg[`DMR_OP_MSB:`DMR_OP_LSB] != `DMR_OP_NORMAL;

  // ------------------------------------------------------------
  // Burst sequencer
  // ------------------------------------------------------------
  always_comb begin
    offs = burst_order_bit ? (start_reg[2:0] ^ k_reg)
                           : (start_reg[2:0] + k_reg);
    col  = (start_reg & ~{7'h00, len_m1_reg}) | {7'h00, offs & len_m1_reg};
  end

  always_comb begin
    state_next  = state_reg;
    start_next  = start_reg;
    k_next      = k_reg;
    len_m1_next = len_m1_reg;
    rd_next     = rd_reg;
    beat_next   = '0;
    unique case (state_reg)
      DMR_IDLE: ;
      DMR_BURST: begin
        beat_next = '{valid: 1'b1, is_read: rd_reg, column: col};
        k_next    = k_reg + 3'h1;
        if (k_reg == len_m1_reg)
          state_next = DMR_IDLE;
      end
    endcase
    // A new read or write with a valid burst length truncates any burst in flight
    if (cmd.valid && (cmd.is_read || cmd.is_write) && len_m1 != 3'h0) begin
      state_next  = DMR_BURST;
      start_next  = cmd.addr[9:0] & col_mask;
      k_next      = 3'h0;
      len_m1_next = len_m1;
      rd_next     = cmd.is_read;
    end
  end

  // Latency pipe: bit i set means first data due i cycles later
  always_comb begin
    pipe_next = {1'b0, pipe_reg[3:1]};
    if (cmd.valid && cmd.is_read && len_m1 != 3'h0) begin
      unique case (read_latency_setting)
        `DMR_RL_2:  pipe_next[1] = 1'b1;
        `DMR_RL_25: pipe_next[1] = 1'b1;
        `DMR_RL_3:  pipe_next[2] = 1'b1;
        default:    pipe_next[2] = 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg  <= DMR_IDLE;
      start_reg  <= 10'h000;
      k_reg      <= 3'h0;
      len_m1_reg <= 3'h0;
      rd_reg     <= 1'b0;
      pipe_reg   <= 4'h0;
      beat_reg   <= '0;
    end else begin
      state_reg  <= state_next;
      start_reg  <= start_next;
      k_reg      <= k_next;
      len_m1_reg <= len_m1_next;
      rd_reg     <= rd_next;
      pipe_reg   <= pipe_next;
      beat_reg   <= beat_next;
    end
  end

  assign beat             = beat_reg;
  assign data_valid       = pipe_reg[0];
  assign data_on_neg_edge = read_latency_setting == `DMR_RL_25;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_rst_self_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    lmr_base |=> !mode_reg[`DMR_DLL_RST_BIT]) else $error("dll reset bit stored");
  a_base_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    lmr_base |=> mode_reg[7:0] == $past(cmd.addr[7:0])) else $error("mode not loaded");
  a_ext_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    lmr_ext |=> ext_reg == $past(cmd.addr)) else $error("ext not loaded");
  a_rst_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
    (lmr_base && cmd.addr[12:7] == 6'h02) |=> dll_rst_reg) else $error("no dll reset");
  // Four cycles hold for any lock count of at least four
  a_lock_wait: assert property (@(posedge sys_clk) disable iff (!rstn)
    dll_rst_reg |=> !dll_locked [*4]) else $error("lock too early");
  a_srx_enable: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cmd.valid && cmd.self_refresh_exit) |=> dll_enabled) else $error("dll not on");
  // Beat was formed one edge earlier; a new command may have moved the block since
  a_wrap_block: assert property (@(posedge sys_clk) disable iff (!rstn)
    beat_reg.valid |->
      ((beat_reg.column ^ $past(start_reg)) & ~{7'h00, $past(len_m1_reg)}) == 10'h000)
    else $error("burst left block");
  a_first_beat: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cmd.valid && cmd.is_read && len_m1 != 3'h0) |=> ##1 beat_reg.column == $past(start_reg))
    else $error("first column wrong");
  a_rl3_timing: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cmd.valid && cmd.is_read && len_m1 != 3'h0 && read_latency_setting == `DMR_RL_3)
    |-> ##3 data_valid) else $error("latency 3 wrong");
  a_rl2_timing: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cmd.valid && cmd.is_read && len_m1 != 3'h0 &&
     (read_latency_setting == `DMR_RL_2 || read_latency_setting == `DMR_RL_25))
    |-> ##2 data_valid) else $error("latency 2 wrong");
  a_col_range: assert property (@(posedge sys_clk) disable iff (!rstn)
    beat_reg.valid |-> (beat_reg.column & ~col_mask) == 10'h000) else $error("col bit");
  c_read_burst: cover property (@(posedge sys_clk) cmd.valid && cmd.is_read && len_m1 == 3'h7);
  c_interleave: cover property (@(posedge sys_clk) beat_reg.valid && burst_order_bit);
  c_dll_lock: cover property (@(posedge sys_clk) $rose(dll_locked));
  c_half_cycle: cover property (@(posedge sys_clk) data_valid && data_on_neg_edge);
endmodule

// ---- test/dmr_ctrl_model.sv ----
/*
  Controller-side model that issues one decoded command per call.
  Assumes the caller waits out lock and idle times between calls.
*/
`timescale 1ns/1ps
module dmr_ctrl_model
  import dmr_pkg::*;
(
  input  wire logic sys_clk,
  output dmr_cmd_t  cmd
);
  initial cmd = '0;
  // kind = {read, write, load, self refresh exit}; valid drops after its edge
  task automatic send(input logic [3:0] kind, input logic [1:0] bank, input logic [12:0] addr);
    @(posedge sys_clk);
    #1 cmd = {1'b1, kind, bank, addr};
    @(posedge sys_clk);
    #1 cmd = '0;
  endtask
endmodule

// ---- test/test_ddr_mode_register_burst_order.sv ----
/*
  Self-checking bench for the mode register block.
  Assumes dmr_core and the controller model; clock 8 ns, reset low 20 cycles.
*/
`timescale 1ns/1ps
module test_ddr_mode_register_burst_order;
  import dmr_pkg::*;
  localparam int LOCK = 4;
  logic       sys_clk;
  logic       rstn;
  dmr_cmd_t   cmd;
  dmr_beat_t  beat;
  logic [2:0] read_latency_setting;
  logic       burst_order_bit, dll_enabled, dll_locked, drive_reduced;
  logic       data_valid, data_on_neg_edge, mode_reserved;
  logic [15:0] seed;
  int         bad_count, samples_checked;
  logic [2:0] lt;

  dmr_core #(.LARGE_DENSITY(1'b1), .LOCK_CYCLES(LOCK)) i_dmr_core (.sys_clk, .rstn, .cmd,
    .beat, .read_latency_setting, .burst_order_bit, .dll_enabled, .dll_locked,
    .drive_reduced, .data_valid, .data_on_neg_edge, .mode_reserved);
  dmr_ctrl_model i_dmr_ctrl_model (.sys_clk, .cmd);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [9:0] col(input logic [9:0] s, input int len, input logic il,
                                     input int k);
    logic [9:0] m;
    m = 10'(len - 1);
    return (s & ~m) | ((il ? (s ^ 10'(k)) : (s + 10'(k))) & m);
  endfunction

  task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Just after edge k the bench sees beat k-1; data_valid seen there is sampled at edge k+1
  task automatic run_burst(input logic rd, input int len, input logic il, input int lat);
    logic [9:0] s;
    seed = lfsr(seed);
    s = seed[9:0];
    i_dmr_ctrl_model.send({rd, ~rd, 2'b00}, 2'h0, {3'h0, s});
    for (int k = 1; k <= 8; k++) begin
      settle();
      chk("beat_valid", 13'(k <= len), 13'(beat.valid));
      if (k <= len) chk("column", 13'(col(s, len, il, k - 1)), 13'(beat.column));
      if (k <= len) chk("beat_read", 13'(rd), 13'(beat.is_read));
      chk("data_valid", 13'(rd && k + 1 == lat), 13'(data_valid));
    end
  endtask

  initial begin
    rstn = 1'b0;
    seed = 16'h1a7d;
    bad_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge sys_clk);
    #1 rstn = 1'b1;
    chk("dll_enabled", 13'h1, 13'(dll_enabled));
    chk("dll_locked", 13'h0, 13'(dll_locked));
    repeat (LOCK + 3) settle();
    chk("dll_locked", 13'h1, 13'(dll_locked));
    i_dmr_ctrl_model.send(4'h2, 2'h1, 13'h0002);
    settle();
    chk("drive_reduced", 13'h1, 13'(drive_reduced));
    i_dmr_ctrl_model.send(4'h2, 2'h1, 13'h0001);
    settle();
    chk("dll_enabled", 13'h0, 13'(dll_enabled));
    i_dmr_ctrl_model.send(4'h2, 2'h1, 13'h0000);
    settle();
    chk("dll_enabled", 13'h1, 13'(dll_enabled));
    chk("drive_reduced", 13'h0, 13'(drive_reduced));
    i_dmr_ctrl_model.send(4'h2, 2'h0, 13'h0132);
    settle();
    chk("dll_locked", 13'h0, 13'(dll_locked));
    chk("latency", 13'h3, 13'(read_latency_setting));
    i_dmr_ctrl_model.send(4'h2, 2'h0, 13'h0032);
    repeat (LOCK + 3) settle();
    chk("dll_locked", 13'h1, 13'(dll_locked));
    i_dmr_ctrl_model.send(4'h2, 2'h3, 13'h0020);
    settle();
    chk("latency", 13'h3, 13'(read_latency_setting));
    // Only 2 and 2.5 are legal at 125 MHz
    for (int i = 0; i < 12; i++) begin
      lt = (i / 6 != 0) ? 3'h6 : 3'h2;
      i_dmr_ctrl_model.send(4'h2, 2'h0, {6'h00, lt, 1'(i / 3), 3'(i % 3 + 1)});
      settle();
      chk("latency", 13'(lt), 13'(read_latency_setting));
      chk("order", 13'(i / 3 % 2), 13'(burst_order_bit));
      chk("neg_edge", 13'(lt == 3'h6), 13'(data_on_neg_edge));
      chk("reserved", 13'h0, 13'(mode_reserved));
      run_burst(1'(i), 1 << (i % 3 + 1), 1'(i / 3), 2);
    end
    i_dmr_ctrl_model.send(4'h2, 2'h0, 13'h0020);
    settle();
    run_burst(1'b1, 0, 1'b0, 0);
    i_dmr_ctrl_model.send(4'h2, 2'h0, 13'h00a2);
    settle();
    chk("reserved", 13'h1, 13'(mode_reserved));
    i_dmr_ctrl_model.send(4'h2, 2'h1, 13'h0001);
    i_dmr_ctrl_model.send(4'h1, 2'h0, 13'h0000);
    settle();
    chk("dll_enabled", 13'h1, 13'(dll_enabled));
    chk("dll_locked", 13'h0, 13'(dll_locked));
    finish_test();
  end

  initial begin
    #(8 * 20000);
    bad_count++;
    finish_test();
  end
endmodule
